// ---- nibble_sub_cfg.svh ----
// offsets, field positions, reset values and opcodes of the subtraction datapath
`ifndef NIBBLE_SUB_CFG_SVH
`define NIBBLE_SUB_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_INSTR    12'h000
`define OFS_PSW      12'h004
`define OFS_INDEX    12'h008
`define OFS_IXINC    12'h00C
`define OFS_REGPTR   12'h010
`define OFS_RESULT   12'h014
`define OFS_MEM_BASE 12'h200

// ----------------------------------------------------------------
// status word bit positions and reset values
// ----------------------------------------------------------------
`define PSW_CY_BIT   0
`define PSW_Z_BIT    1
`define PSW_CMP_BIT  2
`define PSW_BCD_BIT  3
`define PSW_IXE_BIT  4
`define PSW_RESET    5'h00
`define INDEX_RESET  12'h000
`define RPTR_RESET   8'h00
`define INSTR_RESET  16'h0000

// ----------------------------------------------------------------
// opcodes and arithmetic constants
// ----------------------------------------------------------------
`define OP_SUB_RM    5'h01
`define OP_SUBTRACT_BORROW_OP_RM   5'h03
`define OP_SUB_MI    5'h11
`define BCD_WRAP     5'h0A

`endif

// ---- nibble_sub_pkg.sv ----
// types shared by the subtraction datapath files
package nibble_sub_pkg;

    // status word as software sees it
    typedef struct packed {
        logic index_enable_flag;
        logic bcd_flag;
        logic compare_flag;
        logic zero_flag;
        logic carry_flag;
    } psw_s;

    // instruction word fields, msb first
    typedef struct packed {
        logic [4:0] opcode;
        logic [2:0] mem_row_field;
        logic [3:0] mem_column_field;
        logic [3:0] operand_nibble;
    } instr_s;

    // one-hot sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } state_e;

endpackage : nibble_sub_pkg

// ---- nibble_sub_alu.sv ----
// one-nibble binary or decimal subtractor with borrow in and out
`timescale 1ns/1ps
`include "nibble_sub_cfg.svh"

module nibble_sub_alu (
    input  wire logic [3:0] minuend,
    input  wire logic [3:0] subtrahend,
    input  wire logic       borrow_in,
    input  wire logic       bcd_mode,
    output logic      [3:0] difference,
    output logic            borrow_out
);

    // ------------------------------------------------------------
    // raw difference, one bit wider to catch the borrow
    // ------------------------------------------------------------
    logic [4:0] raw;
    logic [4:0] adj;

    assign raw = {1'b0, minuend} - {1'b0, subtrahend} - {4'h0, borrow_in};

    // decimal: a negative result wraps by ten, not sixteen
    assign adj = raw + `BCD_WRAP;

    // decimal mode picks the corrected value when the raw difference borrows
    assign difference = (bcd_mode && raw[4]) ? adj[3:0] : raw[3:0];
    assign borrow_out = raw[4];

endmodule : nibble_sub_alu

// ---- nibble_subtract_datapath.sv ----
// four-bit subtraction datapath with its data memory and ahb-lite registers
//
// Behaviour
// - reg minus memory written back to register
// - compare flag suppresses write, flags still update
// - carry flag set on borrow, else cleared
// - nonzero result always clears zero flag
// - zero result, compare clear: set zero
// - zero result, compare set: zero unchanged
// - decimal flag selects binary or decimal subtraction
// - decimal mode stores the corrected difference
// - memory minus immediate written back to memory
// - borrow form subtracts carry flag as well
// - decode opcode, row, column, operand fields
// - opcode 10001 is memory minus immediate
// - index enable ORs index into memory address
// - register operand is low four bits only
// - register row is pointer low shifted right
// - index increments as one twelve-bit value
//
// The address map and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`include "nibble_sub_cfg.svh"

module nibble_subtract_datapath #(
    parameter int MEM_DEPTH = 128
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata
);

    // index width of the nibble store; the default holds eight rows of sixteen
    localparam int AW = $clog2(MEM_DEPTH);

    // ------------------------------------------------------------
    // address match helpers
    // ------------------------------------------------------------

    // true when a byte address hits one register word
    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
        reg_hit = (a[11:2] == ofs[11:2]);
    endfunction : reg_hit

    // true when a byte address falls in the data memory window
    function automatic logic mem_hit(input logic [11:0] a);
        mem_hit = (a >= `OFS_MEM_BASE) &&
                  (({2'b00, a[11:2]} - (`OFS_MEM_BASE >> 2)) < 12'(MEM_DEPTH));
    endfunction : mem_hit

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    nibble_sub_pkg::state_e state_q;
    nibble_sub_pkg::state_e state_d;
    nibble_sub_pkg::psw_s   psw_q;
    nibble_sub_pkg::instr_s instr_q;

    logic [11:0] index_pointer_q;
    logic [3:0]  reg_pointer_low_q;
    logic [3:0]  reg_pointer_high_q;
    logic [3:0]  mem_q [MEM_DEPTH];
    logic [3:0]  result_q;
    logic        borrow_q;
    logic        bad_op_q;

    // bus data-phase bookkeeping
    logic        wr_pend_q;
    logic        rd_pend_q;
    logic [11:0] addr_q;
    logic [31:0] hrdata_q;

    // ------------------------------------------------------------
    // bus address phase
    // ------------------------------------------------------------
    logic accept;
    logic wr_done;
    logic rd_take;

    // hsize is not decoded: every register is one aligned word
    // a transfer is taken when selected, nonsequential or sequential (htrans[1] set), and the bus is ready
    assign accept  = hsel && htrans[1] && hready;
    // the write lands at the end of its data phase
    assign wr_done = wr_pend_q && hreadyout;
    // read data is captured one cycle into the data phase
    assign rd_take = rd_pend_q;

    // ------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------
    logic wr_instr;
    logic wr_psw;
    logic wr_index;
    logic wr_ixinc;
    logic wr_rptr;
    logic wr_mem;

    assign wr_instr = wr_done && reg_hit(addr_q, `OFS_INSTR);
    assign wr_psw   = wr_done && reg_hit(addr_q, `OFS_PSW);
    assign wr_index = wr_done && reg_hit(addr_q, `OFS_INDEX);
    assign wr_ixinc = wr_done && reg_hit(addr_q, `OFS_IXINC);
    assign wr_rptr  = wr_done && reg_hit(addr_q, `OFS_REGPTR);
    assign wr_mem   = wr_done && mem_hit(addr_q);

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    logic is_sub_rm;
    logic is_subtract_borrow_op_rm;
    logic is_sub_mi;
    logic known_op;

    // field split follows the instruction layout
    assign is_sub_rm  = (instr_q.opcode == `OP_SUB_RM);
    assign is_subtract_borrow_op_rm = (instr_q.opcode == `OP_SUBTRACT_BORROW_OP_RM);
    assign is_sub_mi  = (instr_q.opcode == `OP_SUB_MI);
    assign known_op   = is_sub_rm || is_subtract_borrow_op_rm || is_sub_mi;

    // ------------------------------------------------------------
    // operand addressing
    // ------------------------------------------------------------
    logic [10:0]   enc_addr;
    logic [10:0]   eff_addr;
    logic [AW-1:0] mem_idx;
    logic [AW-1:0] gr_idx;
    logic [2:0]    gr_row;

    // data memory address from the row and column fields
    assign enc_addr = {4'h0, instr_q.mem_row_field, instr_q.mem_column_field};

    // index ORs in only when enabled
    assign eff_addr = psw_q.index_enable_flag ? (enc_addr | index_pointer_q[10:0]) : enc_addr;
    assign mem_idx  = eff_addr[AW-1:0];

    // pointer low selects pairs of columns' rows: four gives row two
    assign gr_row = reg_pointer_low_q[3:1];

    // column is the low operand nibble, never touched by the index
    assign gr_idx = AW'({gr_row, instr_q.operand_nibble});

    // ------------------------------------------------------------
    // arithmetic
    // ------------------------------------------------------------
    logic [3:0] minuend;
    logic [3:0] subtrahend;
    logic       borrow_in;
    logic [3:0] diff;
    logic       borrow_out;

    // register forms take register minus memory, immediate form memory minus field
    assign minuend    = is_sub_mi ? mem_q[mem_idx] : mem_q[gr_idx];
    assign subtrahend = is_sub_mi ? instr_q.operand_nibble : mem_q[mem_idx];

    // only the borrow form consumes the carry flag
    assign borrow_in = is_subtract_borrow_op_rm && psw_q.carry_flag;

    nibble_sub_alu u_alu (
        .minuend    (minuend),
        .subtrahend (subtrahend),
        .borrow_in  (borrow_in),
        .bcd_mode   (psw_q.bcd_flag),
        .difference (diff),
        .borrow_out (borrow_out)
    );

    // ------------------------------------------------------------
    // execution control
    // ------------------------------------------------------------
    logic exec;
    logic wb_en;
    logic [AW-1:0] wb_idx;

    assign exec = (state_q == nibble_sub_pkg::ST_EXEC) && known_op;

    // compare mode computes but never stores
    assign wb_en  = exec && !psw_q.compare_flag;
    // destination: memory for immediate form, register otherwise
    assign wb_idx = is_sub_mi ? mem_idx : gr_idx;

    // a write to the instruction register runs it on the next cycle
    always_comb begin
        case (state_q)
            nibble_sub_pkg::ST_IDLE: state_d = wr_instr ? nibble_sub_pkg::ST_EXEC : nibble_sub_pkg::ST_IDLE;
            nibble_sub_pkg::ST_EXEC: state_d = nibble_sub_pkg::ST_IDLE;
            default:                 state_d = nibble_sub_pkg::ST_IDLE;
        endcase
    end

    // sequencer: idle until an instruction word lands, then one execute cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= nibble_sub_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // flag update
    // ------------------------------------------------------------
    logic zero_next;

    // nonzero clears, zero sets unless comparing, then it holds
    assign zero_next = (diff != 4'h0) ? 1'b0 : (psw_q.compare_flag ? psw_q.zero_flag : 1'b1);

    // execution and software writes never meet: the bus stalls during execution
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            psw_q <= `PSW_RESET;
        end else if (exec) begin
            psw_q.carry_flag <= borrow_out;
            psw_q.zero_flag  <= zero_next;
        end else if (wr_psw) begin
            psw_q <= hwdata[4:0];
        end
    end

    // ------------------------------------------------------------
    // instruction, pointers and last result
    // ------------------------------------------------------------
    // only written while idle, so a running instruction never sees its word change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            instr_q <= `INSTR_RESET;
        end else if (wr_instr) begin
            instr_q <= hwdata[15:0];
        end
    end

    // index counts as one value so carries ripple low to high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            index_pointer_q <= `INDEX_RESET;
        end else if (wr_index) begin
            index_pointer_q <= hwdata[11:0];
        end else if (wr_ixinc) begin
            index_pointer_q <= index_pointer_q + 12'h001;
        end
    end

    // pointer high is kept for software only: the store has a single bank
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {reg_pointer_high_q, reg_pointer_low_q} <= `RPTR_RESET;
        end else if (wr_rptr) begin
            {reg_pointer_high_q, reg_pointer_low_q} <= hwdata[7:0];
        end
    end

    // last difference kept for software even when compare suppressed the store
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_q <= 4'h0;
            borrow_q <= 1'b0;
            bad_op_q <= 1'b0;
        end else if (state_q == nibble_sub_pkg::ST_EXEC) begin
            result_q <= known_op ? diff : result_q;
            borrow_q <= known_op ? borrow_out : borrow_q;
            bad_op_q <= !known_op;
        end
    end

    // ------------------------------------------------------------
    // data memory
    // ------------------------------------------------------------

    // one write port: execution write-back or a bus write, never both at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem_q[i] <= 4'h0;
            end
        end else if (wb_en) begin
            mem_q[wb_idx] <= diff;
        end else if (wr_mem) begin
            mem_q[AW'(addr_q[11:2] - (`OFS_MEM_BASE >> 2))] <= hwdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [31:0] rd_val;
    logic [AW-1:0] rd_idx;

    assign rd_idx = AW'(addr_q[11:2] - (`OFS_MEM_BASE >> 2));

    // unmapped words read as zero
    assign rd_val =
        reg_hit(addr_q, `OFS_INSTR)  ? {16'h0000, instr_q} :
        reg_hit(addr_q, `OFS_PSW)    ? {27'h0000000, psw_q} :
        reg_hit(addr_q, `OFS_INDEX)  ? {20'h00000, index_pointer_q} :
        reg_hit(addr_q, `OFS_REGPTR) ? {24'h000000, reg_pointer_high_q, reg_pointer_low_q} :
        reg_hit(addr_q, `OFS_RESULT) ? {23'h000000, bad_op_q, 3'h0, borrow_q, result_q} :
        mem_hit(addr_q)              ? {28'h0000000, mem_q[rd_idx]} :
                                       32'h00000000;

    // ------------------------------------------------------------
    // bus data phase
    // ------------------------------------------------------------

    // reads cost one wait state so hrdata comes from a flip-flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 12'h000;
        end else begin
            if (hreadyout) begin
                wr_pend_q <= accept && hwrite;
                rd_pend_q <= accept && !hwrite;
                addr_q    <= accept ? haddr : addr_q;
            end else if (rd_take) begin
                rd_pend_q <= 1'b0;
            end
        end
    end

    // hrdata holds until the next read capture, so a slow master still sees it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (rd_take) begin
            hrdata_q <= rd_val;
        end
    end

    // stall during execution so flags read back settled and bus writes cannot collide
    assign hreadyout = (state_q != nibble_sub_pkg::ST_EXEC) && !rd_pend_q;
    assign hresp     = 1'b0; // always okay
    assign hrdata    = hrdata_q;

endmodule : nibble_subtract_datapath

// ---- nibble_sub_properties.sv ----
// concurrent checks on the bus ports of the subtraction datapath
`timescale 1ns/1ps

module nibble_sub_properties (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata
);
    // ----------------------------------------------------------------
    // transfer decode and checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // a transfer is taken only when the bus is ready
    wire  taken    = hsel & htrans[1] & hready;
    wire  rd_take  = taken & !hwrite;
    wire  ins_wr   = taken & hwrite & (haddr[11:2] == 10'h000);
    wire  oth_wr   = taken & hwrite & (haddr[11:2] != 10'h000);
    wire  zero_rd  = rd_take & ((haddr[11:2] == 10'h003) | ((haddr >= 12'h018) & (haddr < 12'h200)));
    logic rd_pend_q;

    // marks the data phase of a read, the only cycle hrdata may reload
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) rd_pend_q <= 1'b0;
        else rd_pend_q <= rd_take;
    end

    okay_resp_a:   assert property (hresp == 1'b0) else $error("response not okay");
    read_wait_a:   assert property (rd_take |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    exec_stall_a:  assert property (ins_wr |=> hreadyout ##1 !hreadyout ##1 hreadyout)
        else $error("execute stall wrong");
    write_nowait_a: assert property (oth_wr |=> hreadyout) else $error("write stalled");
    stall_once_a:  assert property (!hreadyout |=> hreadyout) else $error("stall longer than one cycle");
    rdata_hold_a:  assert property (!rd_pend_q |=> $stable(hrdata)) else $error("read data moved");
    zero_read_a:   assert property (zero_rd |-> ##2 hrdata == 32'h0) else $error("unmapped read not zero");
    upper_zero_a:  assert property (hrdata[31:16] == 16'h0) else $error("upper read bits set");

    cover property (ins_wr ##2 hreadyout);
    cover property (rd_take ##2 hreadyout);
    cover property (zero_rd);
endmodule : nibble_sub_properties

// ---- ahb_master_model.sv ----
// single-transfer ahb-lite master standing in for the software side
`timescale 1ns/1ps

module ahb_master_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [11:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    // idle bus at time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 12'h000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'b010;
        hwdata = 32'h0;
    end

    // called just after a rising edge; no overlap of transfers, so each waits its own answer
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        hsize  <= 3'b010;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= w ? wd : ~hwdata; // a read inverts hwdata, so back-to-back reads alternate it with the last write data
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : xfer
endmodule : ahb_master_model

// ---- tb.sv ----
// self-checking bench for the subtraction datapath
`timescale 1ns/1ps
`include "nibble_sub_cfg.svh"

module tb;
    typedef struct packed {
        logic [4:0]  psw;
        logic [3:0]  rp;
        logic [11:0] ix;
        logic [3:0]  rv;
        logic [3:0]  mv;
        logic [15:0] ins;
        logic [4:0]  psw_x;
        logic [3:0]  rv_x;
        logic [3:0]  mv_x;
    } case_s;

    logic        hclk;
    logic        hresetn;
    wire logic   hsel;
    wire logic [11:0] haddr;
    wire logic [1:0]  htrans;
    wire logic   hwrite;
    wire logic [2:0]  hsize;
    wire logic [31:0] hwdata;
    wire logic   hreadyout;
    wire logic   hresp;
    wire logic [31:0] hrdata;
    int          err_count;
    int          n_compared;
    int          cyc;
    case_s       c;
    logic [6:0]  ri;
    logic [6:0]  mi;
    // psw {ixe,bcd,cmp,z,cy}, reg ptr, index, reg, mem, instr, psw out, reg out, mem out
    case_s rows [17] = '{
        '{5'h00, 4'h0, 12'h000, 4'h7, 4'h3, 16'h0AF3, 5'h00, 4'h4, 4'h3},
        '{5'h02, 4'h0, 12'h000, 4'h3, 4'h7, 16'h0AF3, 5'h01, 4'hC, 4'h7},
        '{5'h01, 4'h0, 12'h000, 4'h5, 4'h5, 16'h0AF3, 5'h02, 4'h0, 4'h5},
        '{5'h04, 4'h0, 12'h000, 4'h5, 4'h5, 16'h0AF3, 5'h04, 4'h5, 4'h5},
        '{5'h06, 4'h0, 12'h000, 4'h5, 4'h5, 16'h0AF3, 5'h06, 4'h5, 4'h5},
        '{5'h06, 4'h0, 12'h000, 4'h2, 4'h9, 16'h0AF3, 5'h05, 4'h2, 4'h9},
        '{5'h01, 4'h0, 12'h000, 4'h8, 4'h3, 16'h1AF3, 5'h00, 4'h4, 4'h3},
        '{5'h01, 4'h0, 12'h000, 4'h0, 4'h0, 16'h1AF3, 5'h01, 4'hF, 4'h0},
        '{5'h08, 4'h0, 12'h000, 4'h3, 4'h5, 16'h0AF3, 5'h09, 4'h8, 4'h5},
        '{5'h08, 4'h0, 12'h000, 4'h9, 4'h4, 16'h0AF3, 5'h08, 4'h5, 4'h4},
        '{5'h00, 4'h0, 12'h000, 4'h0, 4'h9, 16'h8AF5, 5'h00, 4'h0, 4'h4},
        '{5'h04, 4'h0, 12'h000, 4'h0, 4'h2, 16'h8AF5, 5'h05, 4'h0, 4'h2},
        '{5'h10, 4'h0, 12'h040, 4'h7, 4'h2, 16'h0AF3, 5'h10, 4'h5, 4'h2},
        '{5'h00, 4'h4, 12'h000, 4'h6, 4'h1, 16'h0AF3, 5'h00, 4'h5, 4'h1},
        '{5'h09, 4'h0, 12'h000, 4'h5, 4'h5, 16'h1AF3, 5'h09, 4'h9, 4'h5},
        '{5'h05, 4'h0, 12'h000, 4'h5, 4'h4, 16'h1AF3, 5'h04, 4'h5, 4'h4},
        '{5'h08, 4'h0, 12'h000, 4'h0, 4'h2, 16'h8AF5, 5'h09, 4'h0, 4'h7}
    };

    // ----------------------------------------------------------------
    // instances, clock and watchdog
    // ----------------------------------------------------------------
    nibble_subtract_datapath DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
    ahb_master_model bus (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // cuts a hung handshake short; the full run needs well under 2000 cycles
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [11:0] mem_a(input logic [6:0] n);
        return `OFS_MEM_BASE + {3'h0, n, 2'b00};
    endfunction : mem_a

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus.xfer(1'b1, a, d, dummy);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] msk);
        logic [31:0] d;
        bus.xfer(1'b0, a, 32'h0, d);
        chk(d & msk, exp);
    endtask : rd

    task automatic stop_test();
        $display("compares %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        hresetn = 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // table rows: general register lies in row regptr_low[3:1], memory may be ORed with the index
        for (int i = 0; i < 17; i++) begin
            c  = rows[i];
            ri = {c.rp[3:1], c.ins[3:0]};
            mi = c.ins[10:4] | (c.psw[4] ? c.ix[6:0] : 7'h00);
            wr(`OFS_PSW, 32'(c.psw));
            wr(`OFS_INDEX, 32'(c.ix));
            wr(`OFS_REGPTR, 32'(c.rp));
            if (c.ins[15:11] !== `OP_SUB_MI) wr(mem_a(ri), 32'(c.rv));
            wr(mem_a(mi), 32'(c.mv));
            wr(`OFS_INSTR, 32'(c.ins));
            rd(`OFS_PSW, 32'(c.psw_x), 32'hFFFFFFFF);
            if (c.ins[15:11] !== `OP_SUB_MI) rd(mem_a(ri), 32'(c.rv_x), 32'hFFFFFFFF);
            rd(mem_a(mi), 32'(c.mv_x), 32'hFFFFFFFF);
        end
        // index increment carries across all three nibbles and wraps at twelve bits
        wr(`OFS_INDEX, 32'h0FF);
        wr(`OFS_IXINC, 32'h1);
        rd(`OFS_INDEX, 32'h100, 32'hFFFFFFFF);
        rd(`OFS_IXINC, 32'h0, 32'hFFFFFFFF);
        wr(`OFS_INDEX, 32'hFFF);
        wr(`OFS_IXINC, 32'h1);
        rd(`OFS_INDEX, 32'h000, 32'hFFFFFFFF);
        // unknown opcode leaves flags alone and is reported
        wr(`OFS_PSW, 32'h03);
        wr(`OFS_INSTR, 32'hF800);
        rd(`OFS_RESULT, 32'h117, 32'hFFFFFFFF);
        rd(`OFS_PSW, 32'h03, 32'hFFFFFFFF);
        rd(`OFS_INSTR, 32'hF800, 32'hFFFFFFFF);
        // unmapped place: write dropped, read zero
        wr(12'h018, 32'h5);
        rd(12'h018, 32'h0, 32'hFFFFFFFF);
        rd(12'h1FC, 32'h0, 32'hFFFFFFFF);
        // second reset in mid-run clears registers and memory
        wr(`OFS_PSW, 32'h1F);
        wr(`OFS_INDEX, 32'hABC);
        wr(`OFS_REGPTR, 32'h55);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(`OFS_PSW, 32'h0, 32'hFFFFFFFF);
        rd(`OFS_INDEX, 32'h0, 32'hFFFFFFFF);
        rd(`OFS_REGPTR, 32'h0, 32'hFFFFFFFF);
        rd(mem_a(7'h2F), 32'h0, 32'hFFFFFFFF);
        stop_test();
    end
endmodule : tb

bind nibble_subtract_datapath nibble_sub_properties chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
